/* rtl/otpl_cfg.svh */
`ifndef OTPL_CFG_SVH
`define OTPL_CFG_SVH

// store geometry
`define OTPL_BITS 75
`define OTPL_WORD_W 10
`define OTPL_NWORDS 8
`define OTPL_IMG_W 80
`define OTPL_LAST_WORD 3'h7
`define OTPL_LOCK_POS 74
`define OTPL_LOCK_WORD 3'h7
`define OTPL_LOCK_MASK 10'h010

// programming pulse per word
`define OTPL_CLK_PERIOD_NS 20
`define OTPL_BURN_TIME_NS 10000
`define OTPL_BURN_CYC ((`OTPL_BURN_TIME_NS + `OTPL_CLK_PERIOD_NS - 1) / `OTPL_CLK_PERIOD_NS)

// field positions inside the stored image
`define OTPL_LOOPA_MSB 1
`define OTPL_LOOPA_LSB 0
`define OTPL_GAIN_MSB 3
`define OTPL_GAIN_LSB 2
`define OTPL_GSET_MSB 7
`define OTPL_GSET_LSB 4
`define OTPL_GTHR_POS 8
`define OTPL_ILIM1_MSB 11
`define OTPL_ILIM1_LSB 10
`define OTPL_ILIM2_MSB 13
`define OTPL_ILIM2_LSB 12
`define OTPL_OVR_MSB 17
`define OTPL_OVR_LSB 16
`define OTPL_SLOPE_MSB 20
`define OTPL_SLOPE_LSB 18
`define OTPL_OVSD_MSB 27
`define OTPL_OVSD_LSB 21
`define OTPL_SINV_POS 28
`define OTPL_PHC_MSB 30
`define OTPL_PHC_LSB 29
`define OTPL_VSET_MSB 37
`define OTPL_VSET_LSB 31
`define OTPL_FSF_MSB 40
`define OTPL_FSF_LSB 38
`define OTPL_EN1_POS 41
`define OTPL_EN2_POS 42
`define OTPL_FSM_MSB 46
`define OTPL_FSM_LSB 44
`define OTPL_TREC_POS 47
`define OTPL_KEEP_POS 48
`define OTPL_PIN_POS 49
`define OTPL_TOFF_MSB 52
`define OTPL_TOFF_LSB 50
`define OTPL_TON_MSB 55
`define OTPL_TON_LSB 53
`define OTPL_PS1_MSB 60
`define OTPL_PS1_LSB 56
`define OTPL_PS2_MSB 65
`define OTPL_PS2_LSB 61
`define OTPL_UV_MSB 73
`define OTPL_UV_LSB 71

`endif

/* rtl/otpl_pkg.sv */
package otpl_pkg;
   typedef logic [9:0] otpl_word_t;
   typedef logic [2:0] otpl_addr_t;
   typedef enum logic [2:0] {
      ST_LOAD = 3'h0,
      ST_IDLE = 3'h1,
      ST_BURN = 3'h3,
      ST_READ = 3'h2
   } otpl_state_e;
endpackage

/* rtl/otpl_fuse_array.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otpl_cfg.svh"
module otpl_fuse_array (
   // clock
   input wire logic mclk_i,
   // fuse write
   input wire logic wr_en_i,
   input wire otpl_pkg::otpl_addr_t wr_addr_i,
   input wire otpl_pkg::otpl_word_t wr_data_i,
   // fuse read
   input wire logic rd_en_i,
   input wire otpl_pkg::otpl_addr_t rd_addr_i,
   output var otpl_pkg::otpl_word_t rd_data_o
);
   import otpl_pkg::*;

   // fuse cells carry no reset: their content survives power cycles
   // an unburnt part reads all zero, otherwise the lock test would see unknowns
   otpl_word_t cells [0:`OTPL_NWORDS-1] = '{default: 10'h000};

   // a blown fuse never returns to zero, so writes only add ones
   always_ff @(posedge mclk_i) begin
      if (wr_en_i) begin
         cells[wr_addr_i] <= cells[wr_addr_i] | wr_data_i;
      end
   end

   // registered read, one cycle latency
   always_ff @(posedge mclk_i) begin
      if (rd_en_i) begin
         rd_data_o <= cells[rd_addr_i];
      end
   end
endmodule
`default_nettype wire

/* rtl/otpl_loader.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otpl_cfg.svh"
module otpl_loader (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // host staging and commands
   input wire logic stage_we_i,
   input wire otpl_pkg::otpl_addr_t stage_addr_i,
   input wire otpl_pkg::otpl_word_t stage_data_i,
   input wire logic prog_req_i,
   input wire logic read_req_i,
   input wire otpl_pkg::otpl_addr_t read_addr_i,
   input wire logic fail_clr_i,
   // host status
   output logic ready_o,
   output logic busy_o,
   output logic locked_o,
   output logic fail_o,
   output logic prog_done_o,
   output logic read_valid_o,
   output var otpl_pkg::otpl_word_t read_data_o,
   // field defaults
   output logic [1:0] booster_loop_ctrl_a_o,
   output logic [1:0] booster_amp_gain_o,
   output logic [3:0] gate_supply_setpoint_o,
   output logic booster_gate_threshold_o,
   output logic [1:0] phase1_current_limit_o,
   output logic [1:0] phase2_current_limit_o,
   output logic [1:0] overvoltage_reaction_o,
   output logic [2:0] booster_slope_ctrl_o,
   output logic [6:0] overvoltage_shutdown_level_o,
   output logic booster_source_invert_o,
   output logic [1:0] phase_count_select_o,
   output logic [6:0] booster_output_setpoint_o,
   output logic [2:0] failsafe_switch_freq_o,
   output logic phase_one_enable_o,
   output logic phase_two_enable_o,
   output logic [2:0] failsafe_mode_select_o,
   output logic thermal_auto_recovery_o,
   output logic logic_supply_keep_on_o,
   output logic shared_pin_function_o,
   output logic [2:0] min_off_time_set_o,
   output logic [2:0] min_on_time_set_o,
   output logic [4:0] power_share_phase_one_o,
   output logic [4:0] power_share_phase_two_o,
   output logic [2:0] gate_supply_undervolt_level_o
);
   import otpl_pkg::*;

   localparam logic [9:0] BURN_CYC = 10'(`OTPL_BURN_CYC);

   otpl_state_e state;
   otpl_state_e next_state;
   otpl_addr_t widx;
   logic rd_pend;
   logic load_last;
   logic [9:0] btimer;
   logic [`OTPL_IMG_W-1:0] img;
   logic img_valid;
   otpl_word_t stage [0:`OTPL_NWORDS-1];
   otpl_word_t arr_rd;
   logic arr_rd_en;
   otpl_addr_t arr_rd_addr;
   logic arr_wr_en;
   otpl_word_t arr_wr_data;
   logic take_prog;
   logic take_read;
   logic burn_end;

   // requests are only taken in idle, so none lands before the load ends
   assign take_prog = (state == ST_IDLE) && prog_req_i && !img[`OTPL_LOCK_POS];
   assign take_read = (state == ST_IDLE) && read_req_i && !prog_req_i;
   assign burn_end = (state == ST_BURN) && (btimer == BURN_CYC - 10'h001);

   // fuse port steering
   assign arr_rd_en = (state == ST_LOAD && !load_last) || take_read;
   assign arr_rd_addr = (state == ST_LOAD) ? widx : read_addr_i;
   assign arr_wr_en = burn_end;
   // lock bit travels with the last word of every burn
   assign arr_wr_data = (widx == `OTPL_LOCK_WORD) ? (stage[widx] | `OTPL_LOCK_MASK) : stage[widx];

   otpl_fuse_array u_fuse (
      .mclk_i(mclk_i),
      .wr_en_i(arr_wr_en),
      .wr_addr_i(widx),
      .wr_data_i(arr_wr_data),
      .rd_en_i(arr_rd_en),
      .rd_addr_i(arr_rd_addr),
      .rd_data_o(arr_rd)
   );

   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_LOAD: begin
            if (load_last && rd_pend) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (take_prog) begin
               next_state = ST_BURN;
            end else if (take_read) begin
               next_state = ST_READ;
            end
         end
         ST_BURN: begin
            // reload after the burn so the lock state is seen at once
            if (burn_end && widx == `OTPL_LAST_WORD) begin
               next_state = ST_LOAD;
            end
         end
         ST_READ: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= ST_LOAD;
         busy_o <= 1'b1;
      end else begin
         state <= next_state;
         busy_o <= (next_state != ST_IDLE);
      end
   end

   // word index and load bookkeeping
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         widx <= 3'h0;
         rd_pend <= 1'b0;
         load_last <= 1'b0;
      end else begin
         case (state)
            ST_LOAD: begin
               rd_pend <= !load_last || !rd_pend;
               if (!load_last) begin
                  widx <= widx + 3'h1;
                  load_last <= (widx == `OTPL_LAST_WORD);
               end
               if (load_last && rd_pend) begin
                  widx <= 3'h0;
                  load_last <= 1'b0;
                  rd_pend <= 1'b0;
               end
            end
            ST_BURN: begin
               if (burn_end) begin
                  widx <= widx + 3'h1;
               end
            end
            default: begin
               widx <= 3'h0;
               rd_pend <= 1'b0;
               load_last <= 1'b0;
            end
         endcase
      end
   end

   // image capture, one word a cycle behind the read address
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         img <= '0;
         img_valid <= 1'b0;
      end else if (state == ST_LOAD && rd_pend) begin
         img <= {arr_rd, img[`OTPL_IMG_W-1:`OTPL_WORD_W]};
         img_valid <= load_last;
      end else if (state != ST_LOAD) begin
         img_valid <= 1'b0;
      end
   end

   // per-word burn pulse timer
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || state != ST_BURN || burn_end) begin
         btimer <= 10'h000;
      end else begin
         btimer <= btimer + 10'h001;
      end
   end

   // staging words, writable only while idle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < `OTPL_NWORDS; i++) begin
            stage[i] <= '0;
         end
      end else if (state == ST_IDLE && stage_we_i) begin
         stage[stage_addr_i] <= stage_data_i;
      end
   end

   // host status; a new failure wins over a clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ready_o <= 1'b0;
         locked_o <= 1'b0;
         fail_o <= 1'b0;
         prog_done_o <= 1'b0;
         read_valid_o <= 1'b0;
         read_data_o <= '0;
      end else begin
         ready_o <= ready_o || (state == ST_LOAD && load_last && rd_pend);
         // lock shown at the edge busy falls, so it never lags the refusal logic
         if (state == ST_LOAD && load_last && rd_pend) begin
            locked_o <= |(arr_rd & `OTPL_LOCK_MASK);
         end
         if (state == ST_IDLE && prog_req_i && img[`OTPL_LOCK_POS]) begin
            fail_o <= 1'b1;
         end else if (fail_clr_i) begin
            fail_o <= 1'b0;
         end
         prog_done_o <= burn_end && (widx == `OTPL_LAST_WORD);
         read_valid_o <= (state == ST_READ);
         if (state == ST_READ) begin
            read_data_o <= arr_rd;
         end
      end
   end

   // field defaults, refreshed when a full image is in; spare bits stay unconnected
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         booster_loop_ctrl_a_o <= '0;
         booster_amp_gain_o <= '0;
         gate_supply_setpoint_o <= '0;
         booster_gate_threshold_o <= 1'b0;
         phase1_current_limit_o <= '0;
         phase2_current_limit_o <= '0;
         overvoltage_reaction_o <= '0;
         booster_slope_ctrl_o <= '0;
         overvoltage_shutdown_level_o <= '0;
         booster_source_invert_o <= 1'b0;
         phase_count_select_o <= '0;
         booster_output_setpoint_o <= '0;
         failsafe_switch_freq_o <= '0;
         phase_one_enable_o <= 1'b0;
         phase_two_enable_o <= 1'b0;
         failsafe_mode_select_o <= '0;
         thermal_auto_recovery_o <= 1'b0;
         logic_supply_keep_on_o <= 1'b0;
         shared_pin_function_o <= 1'b0;
         min_off_time_set_o <= '0;
         min_on_time_set_o <= '0;
         power_share_phase_one_o <= '0;
         power_share_phase_two_o <= '0;
         gate_supply_undervolt_level_o <= '0;
      end else if (img_valid) begin
         booster_loop_ctrl_a_o <= img[`OTPL_LOOPA_MSB:`OTPL_LOOPA_LSB];
         booster_amp_gain_o <= img[`OTPL_GAIN_MSB:`OTPL_GAIN_LSB];
         gate_supply_setpoint_o <= img[`OTPL_GSET_MSB:`OTPL_GSET_LSB];
         booster_gate_threshold_o <= img[`OTPL_GTHR_POS];
         phase1_current_limit_o <= img[`OTPL_ILIM1_MSB:`OTPL_ILIM1_LSB];
         phase2_current_limit_o <= img[`OTPL_ILIM2_MSB:`OTPL_ILIM2_LSB];
         overvoltage_reaction_o <= img[`OTPL_OVR_MSB:`OTPL_OVR_LSB];
         booster_slope_ctrl_o <= img[`OTPL_SLOPE_MSB:`OTPL_SLOPE_LSB];
         overvoltage_shutdown_level_o <= img[`OTPL_OVSD_MSB:`OTPL_OVSD_LSB];
         booster_source_invert_o <= img[`OTPL_SINV_POS];
         phase_count_select_o <= img[`OTPL_PHC_MSB:`OTPL_PHC_LSB];
         booster_output_setpoint_o <= img[`OTPL_VSET_MSB:`OTPL_VSET_LSB];
         failsafe_switch_freq_o <= img[`OTPL_FSF_MSB:`OTPL_FSF_LSB];
         phase_one_enable_o <= img[`OTPL_EN1_POS];
         phase_two_enable_o <= img[`OTPL_EN2_POS];
         failsafe_mode_select_o <= img[`OTPL_FSM_MSB:`OTPL_FSM_LSB];
         thermal_auto_recovery_o <= img[`OTPL_TREC_POS];
         logic_supply_keep_on_o <= img[`OTPL_KEEP_POS];
         shared_pin_function_o <= img[`OTPL_PIN_POS];
         min_off_time_set_o <= img[`OTPL_TOFF_MSB:`OTPL_TOFF_LSB];
         min_on_time_set_o <= img[`OTPL_TON_MSB:`OTPL_TON_LSB];
         power_share_phase_one_o <= img[`OTPL_PS1_MSB:`OTPL_PS1_LSB];
         power_share_phase_two_o <= img[`OTPL_PS2_MSB:`OTPL_PS2_LSB];
         gate_supply_undervolt_level_o <= img[`OTPL_UV_MSB:`OTPL_UV_LSB];
      end
   end
endmodule
`default_nettype wire

/* testbench/otpl_loader_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module otpl_loader_asserts (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // host requests
   input wire logic prog_req_i,
   input wire logic read_req_i,
   input wire logic fail_clr_i,
   // status seen by the host
   input wire logic ready_o,
   input wire logic busy_o,
   input wire logic locked_o,
   input wire logic fail_o,
   input wire logic prog_done_o,
   input wire logic read_valid_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_ready_sticky: assert property (ready_o |=> ready_o) else $error("ready dropped");
   a_busy_until_ready: assert property (!ready_o |-> busy_o) else $error("idle before load");
   a_locked_refused: assert property (prog_req_i && !busy_o && locked_o |=> fail_o && !busy_o)
      else $error("locked program not refused");
   a_prog_starts: assert property (prog_req_i && !busy_o && !locked_o |=> busy_o)
      else $error("program not started");
   a_fail_sticky: assert property (fail_o && !fail_clr_i |=> fail_o) else $error("fail lost");
   a_fail_clear: assert property (fail_clr_i && !(prog_req_i && !busy_o && locked_o) |=> !fail_o)
      else $error("fail not cleared");
   a_done_pulse: assert property (prog_done_o |=> !prog_done_o) else $error("done too long");
   a_done_locks: assert property (prog_done_o |-> ##[1:20] (locked_o && !busy_o))
      else $error("no lock after burn");
   a_read_answer: assert property (read_req_i && !prog_req_i && !busy_o
      |=> busy_o ##1 (read_valid_o && !busy_o)) else $error("read answer late");
   a_valid_pulse: assert property (read_valid_o |=> !read_valid_o) else $error("valid too long");
endmodule
`default_nettype wire

/* testbench/otpl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module otpl_host_model (
   // clock
   input wire logic mclk_i,
   // requests toward the loader
   output logic stage_we_o,
   output var otpl_pkg::otpl_addr_t stage_addr_o,
   output var otpl_pkg::otpl_word_t stage_data_o,
   output logic prog_req_o,
   output logic read_req_o,
   output var otpl_pkg::otpl_addr_t read_addr_o,
   output logic fail_clr_o
);
   import otpl_pkg::*;
   // quiet host at time zero
   initial begin
      stage_we_o = 1'b0;
      stage_addr_o = 3'h0;
      stage_data_o = 10'h000;
      prog_req_o = 1'b0;
      read_req_o = 1'b0;
      read_addr_o = 3'h0;
      fail_clr_o = 1'b0;
   end
   // strobes held across exactly one rising edge, so one request each
   task stage(input otpl_addr_t a, input otpl_word_t d);
      @(negedge mclk_i);
      stage_we_o = 1'b1;
      stage_addr_o = a;
      stage_data_o = d;
      @(negedge mclk_i);
      stage_we_o = 1'b0;
   endtask
   task prog();
      @(negedge mclk_i);
      prog_req_o = 1'b1;
      @(negedge mclk_i);
      prog_req_o = 1'b0;
   endtask
   task rd(input otpl_addr_t a);
      @(negedge mclk_i);
      read_req_o = 1'b1;
      read_addr_o = a;
      @(negedge mclk_i);
      read_req_o = 1'b0;
   endtask
   task clr();
      @(negedge mclk_i);
      fail_clr_o = 1'b1;
      @(negedge mclk_i);
      fail_clr_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import otpl_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic stage_we, prog_req, read_req, fail_clr, ready, busy, locked, fail, done, rvalid;
   otpl_addr_t stage_addr, read_addr;
   otpl_word_t stage_data, rdata;
   wire [64:0] flds;
   logic [79:0] img;
   logic [31:0] seed = 32'h6C7C25F0;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   // 50 MHz
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   otpl_host_model i_host (.mclk_i(mclk_i), .stage_we_o(stage_we), .stage_addr_o(stage_addr),
      .stage_data_o(stage_data), .prog_req_o(prog_req), .read_req_o(read_req), .read_addr_o(read_addr),
      .fail_clr_o(fail_clr));
   otpl_loader i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .stage_we_i(stage_we), .stage_addr_i(stage_addr),
      .stage_data_i(stage_data), .prog_req_i(prog_req), .read_req_i(read_req), .read_addr_i(read_addr),
      .fail_clr_i(fail_clr), .ready_o(ready), .busy_o(busy), .locked_o(locked), .fail_o(fail),
      .prog_done_o(done), .read_valid_o(rvalid), .read_data_o(rdata),
      .booster_loop_ctrl_a_o(flds[1:0]), .booster_amp_gain_o(flds[3:2]), .gate_supply_setpoint_o(flds[7:4]),
      .booster_gate_threshold_o(flds[8]), .phase1_current_limit_o(flds[10:9]),
      .phase2_current_limit_o(flds[12:11]), .overvoltage_reaction_o(flds[14:13]),
      .booster_slope_ctrl_o(flds[17:15]), .overvoltage_shutdown_level_o(flds[24:18]),
      .booster_source_invert_o(flds[25]), .phase_count_select_o(flds[27:26]),
      .booster_output_setpoint_o(flds[34:28]), .failsafe_switch_freq_o(flds[37:35]),
      .phase_one_enable_o(flds[38]), .phase_two_enable_o(flds[39]), .failsafe_mode_select_o(flds[42:40]),
      .thermal_auto_recovery_o(flds[43]), .logic_supply_keep_on_o(flds[44]), .shared_pin_function_o(flds[45]),
      .min_off_time_set_o(flds[48:46]), .min_on_time_set_o(flds[51:49]), .power_share_phase_one_o(flds[56:52]),
      .power_share_phase_two_o(flds[61:57]), .gate_supply_undervolt_level_o(flds[64:62]));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // spare positions, the lock position and the unused top of the image
   function automatic bit unmapped(input int i);
      return i == 9 || i == 14 || i == 15 || i == 43 || (i >= 66 && i <= 70) || i >= 74;
   endfunction
   // field outputs are the image with unmapped bits squeezed out
   function automatic logic [64:0] exp_fields(input logic [79:0] m);
      logic [64:0] f;
      int k;
      k = 0;
      f = '0;
      for (int i = 0; i < 80; i++) begin
         if (!unmapped(i)) begin
            f[k] = m[i];
            k++;
         end
      end
      return f;
   endfunction
   task chk(input logic [79:0] got, input logic [79:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait for a design flag to reach a level
   task automatic wait_lvl(ref logic s, input logic lvl, input int n);
      int t;
      t = 0;
      while (s !== lvl && t < n) begin
         @(posedge mclk_i);
         #1;
         t++;
      end
      chk(s, lvl);
   endtask
   task reset_dut();
      @(negedge mclk_i);
      sys_rst_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      wait_lvl(busy, 1'b0, 40);
      // field outputs follow one edge after busy falls
      @(posedge mclk_i);
      #1;
   endtask
   task conclude();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // guard against a hang: one burn is about 4000 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      wait_lvl(busy, 1'b0, 40);
      chk(ready, 1'b1);
      img[31:0] = seed;
      seed = lfsr(seed);
      img[63:32] = seed;
      seed = lfsr(seed);
      img[79:64] = seed[15:0];
      for (int i = 0; i < 80; i++) begin
         if (unmapped(i)) img[i] = 1'b0;
      end
      for (int k = 0; k < 8; k++) i_host.stage(k[2:0], img[10*k +: 10]);
      i_host.prog();
      i_host.stage(3'h0, ~img[9:0]);
      wait_lvl(done, 1'b1, 4200);
      wait_lvl(busy, 1'b0, 40);
      @(posedge mclk_i);
      #1;
      img[74] = 1'b1;
      chk(locked, 1'b1);
      chk(flds, exp_fields(img));
      i_host.stage(3'h0, ~img[9:0]);
      i_host.prog();
      @(posedge mclk_i);
      #1;
      chk({fail, busy}, 2'b10);
      i_host.clr();
      @(posedge mclk_i);
      #1;
      chk(fail, 1'b0);
      for (int k = 0; k < 8; k++) begin
         i_host.rd(k[2:0]);
         wait_lvl(rvalid, 1'b1, 4);
         chk(rdata, img[10*k +: 10]);
      end
      reset_dut();
      chk(ready, 1'b1);
      chk(flds, exp_fields(img));
      chk(locked, 1'b1);
      conclude();
   end
endmodule
bind otpl_loader otpl_loader_asserts i_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .prog_req_i(prog_req_i),
   .read_req_i(read_req_i), .fail_clr_i(fail_clr_i), .ready_o(ready_o), .busy_o(busy_o), .locked_o(locked_o),
   .fail_o(fail_o), .prog_done_o(prog_done_o), .read_valid_o(read_valid_o));
`default_nettype wire
